// ### ddi_top.v
`timescale 1ns/1ps
`include "ddi_regs.vh"

// What this block does
// - freeze output: only dc-brake on 27/19 stops
// - setup from two inputs in multi-setup
// - preset enable picks remote/pulse or preset reference
// - two inputs choose preset one to four
// - speed up/down only while frozen
// - held up/down ramps at set rates
// - each pulse steps one tenth unit
// - frozen value editable stopped, kept externally
// - start needs run permissive and start
// - any permissive terminal high suffices
// - jog forces jog speed, blocked by 27
// - local reference forces open loop
// - lock refuses panel writes, bus allowed
// - pulse reference scaled from range low to range high
// - pulse feedback scaled by its max
// - hand start runs, low stops unless auto
// - terminal hand/auto beats panel keys
// - auto start selects auto mode
// - auto beats hand, neither means off
// - fire mode from 16/17 when enabled
// - fire ends on input low or 27 open
// - inverse fire acts on low level
// - rtc enable starts scheduled actions
// - start high runs, low stops
// - freeze reference holds, only up/down or a frozen-value write change
module ddi_top #(
    parameter GATE_CYC = `DDI_GATE_CYC
) (
    // clock and reset
    input wire REF_CLK_I,
    input wire RESET_N_I,
    // register port
    input wire [7:0] ADDR_I,
    input wire [31:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    output reg [31:0] RDATA_O,
    // terminals 16,17,18,19,27,29,32,33
    input wire [7:0] TERM_I,
    // drive side inputs
    input wire [15:0] REMOTE_REF_I,
    input wire [15:0] OUT_FREQ_I,
    input wire TRIP_I,
    input wire KEY_HAND_I,
    input wire KEY_AUTO_I,
    input wire KEY_OFF_I,
    input wire LCP_WR_REQ_I,
    input wire BUS_WR_REQ_I,
    // drive commands
    output reg RUN_O,
    output reg [15:0] SPEED_O,
    output reg [1:0] SETUP_O,
    output reg CLOSED_LOOP_O,
    output reg PARAM_WR_OK_O,
    output reg FIRE_O,
    output reg AUTO_RESET_O,
    output reg RTC_EN_O,
    output reg [2:0] MODE_O,
    output reg [15:0] PULSE_REF_O,
    output reg [15:0] PULSE_FB_O,
    output reg [15:0] FROZEN_O
);

    localparam M_OFF = 3'b001;
    localparam M_HAND = 3'b010;
    localparam M_AUTO = 3'b100;
    localparam integer GATE_M1 = GATE_CYC - 1;
    localparam [25:0] GATE_LAST = GATE_M1[25:0];

    // true when any terminal with this code is at the wanted level
    function fn_hit;
        input [39:0] codes;
        input [7:0] lv;
        input [4:0] code;
        input pol;
        integer k;
        begin
            fn_hit = 1'b0;
            for (k = 0; k < 8; k = k + 1) begin
                if (codes[k*5 +: 5] == code && lv[k] == pol) begin
                    fn_hit = 1'b1;
                end
            end
        end
    endfunction

    // true when any terminal carries this code
    function fn_used;
        input [39:0] codes;
        input [4:0] code;
        integer k;
        begin
            fn_used = 1'b0;
            for (k = 0; k < 8; k = k + 1) begin
                if (codes[k*5 +: 5] == code) begin
                    fn_used = 1'b1;
                end
            end
        end
    endfunction

    // lo + f*(hi-lo)/pmax with f clipped to pmax
    function [15:0] fn_scale;
        input [15:0] f;
        input [15:0] pmax;
        input [15:0] lo;
        input [15:0] hi;
        reg [31:0] prod;
        reg [31:0] quo;
        begin
            prod = 32'h00000000;
            quo = 32'h00000000;
            if (pmax == 16'h0000) begin
                fn_scale = lo;
            end else begin
                prod = ((f > pmax) ? pmax : f) * (hi - lo);
                // quotient never exceeds hi-lo, so the low half holds it
                quo = prod / {16'h0000, pmax};
                fn_scale = lo + quo[15:0];
            end
        end
    endfunction

    // registers
    reg [31:0] func_a_ff, func_b_ff, cfg_ff, jog_fire_ff, ramp_ff;
    reg [31:0] preset01_ff, preset23_ff, pulse_max_ff, ref_range_ff;
    reg [15:0] frozen_ff;
    reg [7:0] sync1_ff, sync2_ff, prev_ff;
    reg [2:0] mode_ff;
    reg run_ff, fire_ff, frz_ref_d_ff, frz_out_d_ff, up_d_ff, dn_d_ff;
    reg [15:0] ramp_cnt_ff, cnt_ref_ff, cnt_fb_ff, meas_ref_ff, meas_fb_ff;
    reg [25:0] gate_ff;

    wire [39:0] codes = {func_b_ff[28:24], func_b_ff[20:16], func_b_ff[12:8], func_b_ff[4:0],
                         func_a_ff[28:24], func_a_ff[20:16], func_a_ff[12:8], func_a_ff[4:0]};
    wire [7:0] lv = sync2_ff;
    wire [7:0] rise = sync2_ff & ~prev_ff;

    // decoded input functions
    wire start_t = fn_hit(codes, lv, `DDI_F_START, 1'b1);
    wire frz_ref = fn_hit(codes, lv, `DDI_F_FRZ_REF, 1'b1);
    wire frz_out = fn_hit(codes, lv, `DDI_F_FRZ_OUT, 1'b1);
    wire up_in = fn_hit(codes, lv, `DDI_F_SPEED_UP, 1'b1);
    wire dn_in = fn_hit(codes, lv, `DDI_F_SPEED_DN, 1'b1);
    wire jog_in = fn_hit(codes, lv, `DDI_F_JOG, 1'b1);
    wire lock_in = fn_hit(codes, lv, `DDI_F_DATA_LOCK, 1'b1);
    wire hand_in = fn_hit(codes, lv, `DDI_F_HAND, 1'b1);
    wire auto_in = fn_hit(codes, lv, `DDI_F_AUTO, 1'b1);
    wire rtc_in = fn_hit(codes, lv, `DDI_F_RTC, 1'b1);
    wire ha_used = fn_used(codes, `DDI_F_HAND) | fn_used(codes, `DDI_F_AUTO);
    // permissive is met when none is assigned or any assigned one is high
    wire perm_ok = ~fn_used(codes, `DDI_F_RUN_PERM) |
                   fn_hit(codes, lv, `DDI_F_RUN_PERM, 1'b1);

    // stop on 27, or dc brake on 19, by a low stop-type function
    wire [4:0] c27 = codes[`DDI_T27*5 +: 5];
    wire [4:0] c19 = codes[`DDI_T19*5 +: 5];
    wire stop27 = ~lv[`DDI_T27] && (c27 == `DDI_F_COAST_INV || c27 == `DDI_F_DC_BRAKE_INV);
    wire dc_stop = (~lv[`DDI_T27] && c27 == `DDI_F_DC_BRAKE_INV) ||
                   (~lv[`DDI_T19] && c19 == `DDI_F_DC_BRAKE_INV);

    // fire request only looks at terminals 16 and 17
    wire [9:0] fcodes = codes[9:0];
    wire fire_req = cfg_ff[`DDI_CFG_FIRE_EN] &&
                    (fn_hit({30'h0, fcodes}, {6'h0, lv[1:0]}, `DDI_F_FIRE, 1'b1) ||
                     fn_hit({30'h0, fcodes}, {6'h3F, lv[1:0]}, `DDI_F_FIRE_INV,
                            1'b0));

    // setup select
    wire [1:0] setup_t = {fn_hit(codes, lv, `DDI_F_SETUP_MSB, 1'b1),
                          fn_hit(codes, lv, `DDI_F_SETUP_LSB, 1'b1)};
    wire [2:0] act_setup = cfg_ff[`DDI_CFG_SETUP_HI:`DDI_CFG_SETUP_LO];
    wire [2:0] setup_m1 = act_setup - 3'h1;
    wire [1:0] setup_sel = (act_setup == `DDI_SETUP_MULTI) ? setup_t : setup_m1[1:0];

    // preset reference choice, 00 is preset 1
    wire [1:0] pre_sel = {fn_hit(codes, lv, `DDI_F_PRESET_MSB, 1'b1),
                          fn_hit(codes, lv, `DDI_F_PRESET_LSB, 1'b1)};
    reg [15:0] preset_val;
    always @* begin
        case (pre_sel)
            2'h0: preset_val = preset01_ff[15:0];
            2'h1: preset_val = preset01_ff[31:16];
            2'h2: preset_val = preset23_ff[15:0];
            default: preset_val = preset23_ff[31:16];
        endcase
    end
    wire pre_on = fn_hit(codes, lv, `DDI_F_PRESET_ON, 1'b1);
    wire preset_mode = cfg_ff[`DDI_CFG_REFT_HI:`DDI_CFG_REFT_LO] == `DDI_REFT_PRESET;
    wire [15:0] pulse_ref = fn_scale(meas_ref_ff, pulse_max_ff[15:0],
                                     ref_range_ff[15:0], ref_range_ff[31:16]);
    wire pulse_used = fn_used(codes, `DDI_F_PULSE_REF);
    wire [15:0] live_ref = (preset_mode && pre_on) ? preset_val :
                           (pulse_used ? pulse_ref : REMOTE_REF_I);

    // up/down stepping: down wins when both are high
    wire frozen_any = frz_ref | frz_out;
    wire step_dn = frozen_any & dn_in;
    wire step_up = frozen_any & up_in & ~dn_in;
    wire [15:0] ramp_lim = step_dn ? ramp_ff[31:16] : ramp_ff[15:0];
    wire first_step = (step_up & ~up_d_ff) | (step_dn & ~dn_d_ff);
    wire ramp_step = (step_up | step_dn) && !first_step && ramp_cnt_ff >= ramp_lim;
    wire [15:0] frz_ceil = frz_out ? 16'hFFFF : `DDI_FRZ_REF_MAX;

    // mode selection
    reg [2:0] nxt_mode;
    always @* begin
        nxt_mode = mode_ff;
        if (ha_used) begin
            // terminal switch overrides the panel keys
            if (auto_in) begin
                nxt_mode = M_AUTO;
            end else if (hand_in) begin
                nxt_mode = M_HAND;
            end else begin
                nxt_mode = M_OFF;
            end
        end else if (KEY_OFF_I) begin
            nxt_mode = M_OFF;
        end else if (KEY_AUTO_I) begin
            nxt_mode = M_AUTO;
        end else if (KEY_HAND_I) begin
            nxt_mode = M_HAND;
        end
    end

    // run decision
    wire jog_go = jog_in & ~stop27;
    wire auto_start = (start_t | cfg_ff[`DDI_CFG_BUS_START]) & perm_ok;
    reg nxt_run;
    always @* begin
        case (mode_ff)
            M_HAND: nxt_run = 1'b1;
            M_AUTO: nxt_run = auto_start;
            M_OFF: nxt_run = 1'b0;
            default: nxt_run = 1'b0;
        endcase
        if (jog_go) begin
            nxt_run = 1'b1;
        end
        // frozen output ignores a start removal, only dc brake stops
        if (frz_out && run_ff) begin
            nxt_run = 1'b1;
        end
        if (dc_stop) begin
            nxt_run = 1'b0;
        end
        if (fire_ff) begin
            nxt_run = 1'b1;
        end
    end

    // synchronisers for the terminals
    always @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
            prev_ff <= 8'h00;
        end else begin
            sync1_ff <= TERM_I;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    // software registers and the frozen value
    always @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            func_a_ff <= `DDI_FUNC_A_RST;
            func_b_ff <= `DDI_FUNC_B_RST;
            cfg_ff <= `DDI_CFG_RST;
            jog_fire_ff <= `DDI_JOG_FIRE_RST;
            ramp_ff <= `DDI_RAMP_RST;
            preset01_ff <= 32'h00000000;
            preset23_ff <= 32'h00000000;
            pulse_max_ff <= `DDI_PULSE_MAX_RST;
            ref_range_ff <= `DDI_REF_RANGE_RST;
            frozen_ff <= 16'h0000;
            ramp_cnt_ff <= 16'h0000;
            frz_ref_d_ff <= 1'b0;
            frz_out_d_ff <= 1'b0;
            up_d_ff <= 1'b0;
            dn_d_ff <= 1'b0;
        end else begin
            frz_ref_d_ff <= frz_ref;
            frz_out_d_ff <= frz_out;
            up_d_ff <= step_up;
            dn_d_ff <= step_dn;
            ramp_cnt_ff <= (first_step || ramp_step || !(step_up | step_dn)) ? 16'h0000 :
                           ramp_cnt_ff + 16'h0001;
            // capture on freeze entry, then only up/down or a DDI_FROZEN write move it
            if (frz_ref && !frz_ref_d_ff) begin
                frozen_ff <= live_ref;
            end else if (frz_out && !frz_out_d_ff) begin
                frozen_ff <= OUT_FREQ_I;
            end else if (first_step || ramp_step) begin
                // one step per pulse edge or ramp interval, no run gating
                if (step_dn) begin
                    frozen_ff <= (frozen_ff == 16'h0000) ? 16'h0000 :
                                 frozen_ff - 16'h0001;
                end else begin
                    frozen_ff <= (frozen_ff >= frz_ceil) ? frz_ceil :
                                 frozen_ff + 16'h0001;
                end
            end else if (WR_I && ADDR_I == `DDI_FROZEN) begin
                // restore path for the value kept across mains loss
                frozen_ff <= WDATA_I[15:0];
            end
            if (WR_I) begin
                case (ADDR_I)
                    `DDI_FUNC_A: func_a_ff <= WDATA_I;
                    `DDI_FUNC_B: func_b_ff <= WDATA_I;
                    `DDI_CFG: cfg_ff <= WDATA_I;
                    `DDI_JOG_FIRE: jog_fire_ff <= WDATA_I;
                    `DDI_RAMP: ramp_ff <= WDATA_I;
                    `DDI_PRESET01: preset01_ff <= WDATA_I;
                    `DDI_PRESET23: preset23_ff <= WDATA_I;
                    `DDI_PULSE_MAX: pulse_max_ff <= WDATA_I;
                    `DDI_REF_RANGE: ref_range_ff <= WDATA_I;
                    default: ;
                endcase
            end
        end
    end

    // pulse counters over a fixed gate; long gate trades latency for resolution
    wire pr_edge = fn_hit(codes, rise, `DDI_F_PULSE_REF, 1'b1);
    wire pf_edge = fn_hit(codes, rise, `DDI_F_PULSE_FB, 1'b1);
    always @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            gate_ff <= 26'h0000000;
            cnt_ref_ff <= 16'h0000;
            cnt_fb_ff <= 16'h0000;
            meas_ref_ff <= 16'h0000;
            meas_fb_ff <= 16'h0000;
        end else if (gate_ff >= GATE_LAST) begin
            gate_ff <= 26'h0000000;
            meas_ref_ff <= cnt_ref_ff;
            meas_fb_ff <= cnt_fb_ff;
            cnt_ref_ff <= {15'h0000, pr_edge};
            cnt_fb_ff <= {15'h0000, pf_edge};
        end else begin
            gate_ff <= gate_ff + 26'h0000001;
            if (pr_edge && cnt_ref_ff != 16'hFFFF) begin
                cnt_ref_ff <= cnt_ref_ff + 16'h0001;
            end
            if (pf_edge && cnt_fb_ff != 16'hFFFF) begin
                cnt_fb_ff <= cnt_fb_ff + 16'h0001;
            end
        end
    end

    // command outputs
    always @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            mode_ff <= M_AUTO;
            run_ff <= 1'b0;
            fire_ff <= 1'b0;
            RUN_O <= 1'b0;
            SPEED_O <= 16'h0000;
            SETUP_O <= 2'h0;
            CLOSED_LOOP_O <= 1'b0;
            PARAM_WR_OK_O <= 1'b0;
            FIRE_O <= 1'b0;
            AUTO_RESET_O <= 1'b0;
            RTC_EN_O <= 1'b0;
            MODE_O <= M_AUTO;
            PULSE_REF_O <= 16'h0000;
            PULSE_FB_O <= 16'h0000;
            FROZEN_O <= 16'h0000;
        end else begin
            mode_ff <= nxt_mode;
            run_ff <= nxt_run;
            // fire holds only while request stands and 27 is closed
            fire_ff <= fire_req & lv[`DDI_T27];
            RUN_O <= nxt_run;
            if (fire_ff) begin
                SPEED_O <= jog_fire_ff[31:16];
            end else if (jog_go) begin
                SPEED_O <= jog_fire_ff[15:0];
            end else if (frozen_any) begin
                SPEED_O <= frozen_ff;
            end else begin
                SPEED_O <= live_ref;
            end
            SETUP_O <= setup_sel;
            CLOSED_LOOP_O <= cfg_ff[`DDI_CFG_CLOSED] & ~cfg_ff[`DDI_CFG_LOCAL];
            PARAM_WR_OK_O <= BUS_WR_REQ_I | (LCP_WR_REQ_I & ~lock_in);
            FIRE_O <= fire_ff;
            AUTO_RESET_O <= fire_ff & TRIP_I;
            RTC_EN_O <= rtc_in;
            MODE_O <= nxt_mode;
            PULSE_REF_O <= pulse_ref;
            PULSE_FB_O <= fn_scale(meas_fb_ff, pulse_max_ff[31:16], 16'h0000,
                                   16'hFFFF);
            FROZEN_O <= frozen_ff;
        end
    end

    // read port, data only in the cycle after the strobe
    always @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            RDATA_O <= 32'h00000000;
        end else if (RD_I) begin
            case (ADDR_I)
                `DDI_FUNC_A: RDATA_O <= func_a_ff;
                `DDI_FUNC_B: RDATA_O <= func_b_ff;
                `DDI_CFG: RDATA_O <= cfg_ff;
                `DDI_JOG_FIRE: RDATA_O <= jog_fire_ff;
                `DDI_RAMP: RDATA_O <= ramp_ff;
                `DDI_PRESET01: RDATA_O <= preset01_ff;
                `DDI_PRESET23: RDATA_O <= preset23_ff;
                `DDI_PULSE_MAX: RDATA_O <= pulse_max_ff;
                `DDI_REF_RANGE: RDATA_O <= ref_range_ff;
                `DDI_FROZEN: RDATA_O <= {16'h0000, frozen_ff};
                `DDI_STATUS: RDATA_O <= {20'h00000, jog_go, frz_out, frz_ref, rtc_in,
                                         lock_in, fire_ff, setup_sel, mode_ff, run_ff};
                `DDI_PULSE_MEAS: RDATA_O <= {meas_fb_ff, meas_ref_ff};
                default: RDATA_O <= 32'h00000000;
            endcase
        end else begin
            RDATA_O <= 32'h00000000;
        end
    end

endmodule // ddi_top

// ### ddi_regs.vh
`ifndef DDI_REGS_VH
`define DDI_REGS_VH

// register byte offsets
`define DDI_FUNC_A 8'h00
`define DDI_FUNC_B 8'h04
`define DDI_CFG 8'h08
`define DDI_JOG_FIRE 8'h0C
`define DDI_RAMP 8'h10
`define DDI_PRESET01 8'h14
`define DDI_PRESET23 8'h18
`define DDI_PULSE_MAX 8'h1C
`define DDI_REF_RANGE 8'h20
`define DDI_FROZEN 8'h24
`define DDI_STATUS 8'h28
`define DDI_PULSE_MEAS 8'h2C

// configuration register fields
`define DDI_CFG_SETUP_HI 2
`define DDI_CFG_SETUP_LO 0
`define DDI_CFG_REFT_HI 5
`define DDI_CFG_REFT_LO 4
`define DDI_CFG_FIRE_EN 8
`define DDI_CFG_LOCAL 9
`define DDI_CFG_CLOSED 10
`define DDI_CFG_BUS_START 11

// parameter values
`define DDI_SETUP_MULTI 3'h5
`define DDI_REFT_PRESET 2'h2

// terminal index of screw terminals 16, 17, 18, 19 and 27
`define DDI_T16 0
`define DDI_T17 1
`define DDI_T18 2
`define DDI_T19 3
`define DDI_T27 4

// input function codes
`define DDI_F_NONE 5'h00
`define DDI_F_START 5'h01
`define DDI_F_FRZ_REF 5'h02
`define DDI_F_FRZ_OUT 5'h03
`define DDI_F_SETUP_LSB 5'h04
`define DDI_F_SETUP_MSB 5'h05
`define DDI_F_PRESET_ON 5'h06
`define DDI_F_PRESET_LSB 5'h07
`define DDI_F_PRESET_MSB 5'h08
`define DDI_F_SPEED_UP 5'h09
`define DDI_F_SPEED_DN 5'h0A
`define DDI_F_RUN_PERM 5'h0B
`define DDI_F_JOG 5'h0C
`define DDI_F_DATA_LOCK 5'h0D
`define DDI_F_PULSE_REF 5'h0E
`define DDI_F_PULSE_FB 5'h0F
`define DDI_F_HAND 5'h10
`define DDI_F_AUTO 5'h11
`define DDI_F_FIRE 5'h12
`define DDI_F_FIRE_INV 5'h13
`define DDI_F_RTC 5'h14
`define DDI_F_DC_BRAKE_INV 5'h15
`define DDI_F_COAST_INV 5'h16

// reset values
`define DDI_FUNC_A_RST 32'h00000001
`define DDI_FUNC_B_RST 32'h00000016
`define DDI_CFG_RST 32'h00000001
`define DDI_JOG_FIRE_RST 32'h01F4000A
`define DDI_RAMP_RST 32'h10001000
`define DDI_PULSE_MAX_RST 32'h13881388
`define DDI_REF_RANGE_RST 32'h03E80000

// frozen reference ceiling, 100.0 percent in 0.1 percent steps
`define DDI_FRZ_REF_MAX 16'h03E8

// pulse gate time: 1000 ms at 50 MHz gives a count in Hz
`define DDI_GATE_MS 1000
`define DDI_CLK_KHZ 50000
`define DDI_GATE_CYC (`DDI_GATE_MS * `DDI_CLK_KHZ)

`endif

// ### ddi_props.sv
`timescale 1ns/1ps
`include "ddi_regs.vh"
module ddi_props (
    // clock, reset, register port
    input wire REF_CLK_I,
    input wire RESET_N_I,
    input wire [7:0] ADDR_I,
    input wire [31:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    input wire [31:0] RDATA_O,
    // terminals and drive side
    input wire [7:0] TERM_I,
    input wire TRIP_I,
    input wire LCP_WR_REQ_I,
    input wire BUS_WR_REQ_I,
    input wire RUN_O,
    input wire [15:0] SPEED_O,
    input wire [1:0] SETUP_O,
    input wire CLOSED_LOOP_O,
    input wire PARAM_WR_OK_O,
    input wire FIRE_O,
    input wire AUTO_RESET_O,
    input wire [2:0] MODE_O
);
    reg [31:0] cfg_ff;
    reg [15:0] fire_spd_ff;
    // shadow of config and fire speed, tracked from bus writes only
    always @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cfg_ff <= `DDI_CFG_RST;
            fire_spd_ff <= 16'h01F4;
        end else if (WR_I && ADDR_I == `DDI_CFG) begin
            cfg_ff <= WDATA_I;
        end else if (WR_I && ADDR_I == `DDI_JOG_FIRE) begin
            fire_spd_ff <= WDATA_I[31:16];
        end
    end
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    rd_idle_zero_a: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
        else $error("read data not zero outside read cycle");
    rd_unmapped_a: assert property ($past(RD_I) && $past(ADDR_I) == 8'h30 |-> RDATA_O == 32'h0)
        else $error("unmapped read not zero");
    wr_bus_ok_a: assert property ($past(BUS_WR_REQ_I) |-> PARAM_WR_OK_O)
        else $error("bus write refused");
    wr_none_a: assert property ($past(!LCP_WR_REQ_I && !BUS_WR_REQ_I) |-> !PARAM_WR_OK_O)
        else $error("write ok without request");
    local_open_a: assert property (cfg_ff[9] && $past(cfg_ff[9]) |-> !CLOSED_LOOP_O)
        else $error("closed loop while local reference");
    fixed_setup_a: assert property ($stable(cfg_ff[2:0]) && cfg_ff[2:0] != 3'h0 &&
        cfg_ff[2:0] < 3'h5 |-> SETUP_O == cfg_ff[1:0] - 2'h1)
        else $error("fixed setup not followed");
    fire_enable_a: assert property ($rose(FIRE_O) |-> $past(cfg_ff[8]))
        else $error("fire mode entered while disabled");
    fire_speed_a: assert property (FIRE_O && $past(FIRE_O) && $stable(fire_spd_ff)
        |-> SPEED_O == fire_spd_ff && RUN_O)
        else $error("fire mode not running at fire speed");
    fire_t27_end_a: assert property ((!TERM_I[`DDI_T27])[*5] |-> !FIRE_O)
        else $error("fire mode kept with terminal 27 open");
    trip_reset_a: assert property ($rose(AUTO_RESET_O) |-> $past(TRIP_I))
        else $error("auto reset without trip");
    mode_hot_a: assert property ($onehot(MODE_O))
        else $error("mode not one-hot");
endmodule // ddi_props
bind ddi_top ddi_props chk_u (.REF_CLK_I, .RESET_N_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
    .RDATA_O, .TERM_I, .TRIP_I, .LCP_WR_REQ_I, .BUS_WR_REQ_I, .RUN_O, .SPEED_O, .SETUP_O,
    .CLOSED_LOOP_O, .PARAM_WR_OK_O, .FIRE_O, .AUTO_RESET_O, .MODE_O);

// ### ddi_switches.sv
`timescale 1ns/1ps
module ddi_switches #(
    parameter HOLD_CYC = 150000
) (
    // clock
    input wire clk_i,
    // terminal levels
    output reg [7:0] term_o
);
    // idle: terminal 27 closed, so no coast stop pending
    initial term_o = 8'h10;
    // change a level, then dwell; 3 ms by default, shortened in sim
    task set_lvl(input [7:0] mask, input val);
        @(posedge clk_i);
        term_o <= val ? (term_o | mask) : (term_o & ~mask);
        repeat (HOLD_CYC) @(posedge clk_i);
    endtask
    // one pulse, high dwell then low dwell
    task pulse(input [7:0] mask);
        set_lvl(mask, 1'b1);
        set_lvl(mask, 1'b0);
    endtask
endmodule // ddi_switches

// ### ddi_top_tb_top.sv
`timescale 1ns/1ps
`include "ddi_regs.vh"
module ddi_top_tb_top;
    // stimulus and observed outputs
    reg REF_CLK_I = 1'b0;
    reg RESET_N_I = 1'b0;
    reg [7:0] ADDR_I = 8'h00;
    reg [31:0] WDATA_I = 32'h0;
    reg WR_I = 1'b0;
    reg RD_I = 1'b0;
    reg TRIP_I = 1'b0;
    reg LCP_WR_REQ_I = 1'b0;
    reg BUS_WR_REQ_I = 1'b0;
    reg KEY_HAND_I = 1'b0, KEY_AUTO_I = 1'b0, KEY_OFF_I = 1'b0;
    reg [15:0] REMOTE_REF_I = 16'h0, OUT_FREQ_I = 16'h0;
    wire [7:0] TERM_I;
    wire [31:0] RDATA_O;
    wire RUN_O, CLOSED_LOOP_O, PARAM_WR_OK_O, FIRE_O, AUTO_RESET_O, RTC_EN_O;
    wire [15:0] SPEED_O, FROZEN_O, PULSE_REF_O, PULSE_FB_O;
    wire [1:0] SETUP_O;
    wire [2:0] MODE_O;
    integer mismatches = 0;
    integer checks_done = 0;
    integer i;
    always #10 REF_CLK_I = ~REF_CLK_I;
    // short pulse gate keeps the run brief
    ddi_top #(.GATE_CYC(100)) dut_u (.REF_CLK_I, .RESET_N_I, .ADDR_I, .WDATA_I, .WR_I,
        .RD_I, .RDATA_O, .TERM_I, .REMOTE_REF_I, .OUT_FREQ_I,
        .TRIP_I, .KEY_HAND_I, .KEY_AUTO_I, .KEY_OFF_I, .LCP_WR_REQ_I,
        .BUS_WR_REQ_I, .RUN_O, .SPEED_O, .SETUP_O, .CLOSED_LOOP_O, .PARAM_WR_OK_O,
        .FIRE_O, .AUTO_RESET_O, .RTC_EN_O, .MODE_O, .PULSE_REF_O, .PULSE_FB_O,
        .FROZEN_O);
    ddi_switches #(.HOLD_CYC(8)) sw_u (.clk_i(REF_CLK_I), .term_o(TERM_I));
    task chk(input string n, input [31:0] e, input [31:0] g);
        checks_done = checks_done + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("Error %0s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge REF_CLK_I) {ADDR_I, WDATA_I, WR_I} <= {a, d, 1'b1};
        @(posedge REF_CLK_I) WR_I <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input [7:0] a, input [31:0] e, input string n);
        @(posedge REF_CLK_I) {ADDR_I, RD_I} <= {a, 1'b1};
        @(posedge REF_CLK_I) RD_I <= 1'b0;
        #1 chk(n, e, RDATA_O);
    endtask
    task t_reset;
        chk("MODE_O", 3'b100, MODE_O);
        rd(`DDI_CFG, `DDI_CFG_RST, "CFG");
        rd(`DDI_FUNC_B, `DDI_FUNC_B_RST, "FUNC_B");
        rd(`DDI_JOG_FIRE, `DDI_JOG_FIRE_RST, "JOG_FIRE");
        rd(8'h30, 32'h0, "UNMAPPED");
    endtask
    task t_start;
        wr(`DDI_FUNC_A, 32'h00000B01);
        REMOTE_REF_I <= 16'h0123;
        wr(`DDI_FUNC_B, 32'h00000B16);
        sw_u.set_lvl(8'h01, 1'b1);
        chk("RUN_O", 0, RUN_O);
        sw_u.set_lvl(8'h20, 1'b1);
        chk("RUN_O", 1, RUN_O);
        sw_u.set_lvl(8'h01, 1'b0);
        chk("RUN_O", 0, RUN_O);
        sw_u.set_lvl(8'hEF, 1'b0);
        wr(`DDI_FUNC_B, `DDI_FUNC_B_RST);
    endtask
    // panel request refused under lock, bus request always taken
    task t_lock;
        wr(`DDI_FUNC_A, 32'h0000140D);
        wr(`DDI_REF_RANGE, 32'h03E80064);
        sw_u.set_lvl(8'h03, 1'b1);
        chk("RTC_EN_O", 1, RTC_EN_O);
        chk("PULSE_REF_O", 16'h0064, PULSE_REF_O);
        chk("PULSE_FB_O", 0, PULSE_FB_O);
        @(posedge REF_CLK_I) LCP_WR_REQ_I <= 1'b1;
        @(posedge REF_CLK_I) #1 chk("WR_OK", 0, PARAM_WR_OK_O);
        @(posedge REF_CLK_I) BUS_WR_REQ_I <= 1'b1;
        @(posedge REF_CLK_I) #1 chk("WR_OK", 1, PARAM_WR_OK_O);
        @(posedge REF_CLK_I) BUS_WR_REQ_I <= 1'b0;
        sw_u.set_lvl(8'h03, 1'b0);
        chk("WR_OK", 1, PARAM_WR_OK_O);
        @(posedge REF_CLK_I) LCP_WR_REQ_I <= 1'b0;
    endtask
    task t_setup;
        wr(`DDI_FUNC_A, 32'h00000504);
        wr(`DDI_CFG, 32'h00000405);
        for (i = 0; i < 4; i = i + 1) begin
            sw_u.set_lvl(8'h01, i[0]);
            sw_u.set_lvl(8'h02, i[1]);
            chk("SETUP_O", i, SETUP_O);
        end
        chk("CLOSED_LOOP_O", 1, CLOSED_LOOP_O);
        wr(`DDI_CFG, 32'h00000603);
        repeat (3) @(posedge REF_CLK_I);
        chk("SETUP_O", 2, SETUP_O);
        chk("CLOSED_LOOP_O", 0, CLOSED_LOOP_O);
        wr(`DDI_CFG, `DDI_CFG_RST);
        sw_u.set_lvl(8'hEF, 1'b0);
    endtask
    task t_fire;
        wr(`DDI_FUNC_A, 32'h00000012);
        sw_u.set_lvl(8'h01, 1'b1);
        chk("FIRE_O", 0, FIRE_O);
        wr(`DDI_CFG, 32'h00000101);
        repeat (4) @(posedge REF_CLK_I);
        chk("FIRE_O", 1, FIRE_O);
        chk("SPEED_O", 16'h01F4, SPEED_O);
        @(posedge REF_CLK_I) TRIP_I <= 1'b1;
        repeat (2) @(posedge REF_CLK_I);
        #1 chk("AUTO_RESET_O", 1, AUTO_RESET_O);
        @(posedge REF_CLK_I) TRIP_I <= 1'b0;
        sw_u.set_lvl(8'h10, 1'b0);
        chk("FIRE_O", 0, FIRE_O);
        sw_u.set_lvl(8'h01, 1'b0);
        sw_u.set_lvl(8'h10, 1'b1);
        wr(`DDI_CFG, `DDI_CFG_RST);
    endtask
    task t_jog;
        wr(`DDI_FUNC_A, 32'h0000000C);
        sw_u.set_lvl(8'h01, 1'b1);
        chk("SPEED_O", 16'h000A, SPEED_O);
        chk("RUN_O", 1, RUN_O);
        sw_u.set_lvl(8'h10, 1'b0);
        chk("RUN_O", 0, RUN_O);
        sw_u.set_lvl(8'h01, 1'b0);
        sw_u.set_lvl(8'h10, 1'b1);
    endtask
    // hand on bit 0, auto on bit 1; auto wins, neither is off
    task t_hand;
        wr(`DDI_FUNC_A, 32'h00001110);
        KEY_HAND_I <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            sw_u.set_lvl(8'h01, i[0]);
            sw_u.set_lvl(8'h02, i[1]);
            chk("MODE_O", (i == 0) ? 1 : (i == 1) ? 2 : 4, MODE_O);
            chk("RUN_O", i == 1, RUN_O);
        end
        sw_u.set_lvl(8'hEF, 1'b0);
        KEY_HAND_I <= 1'b0;
    endtask
    task t_frz;
        wr(`DDI_FUNC_A, 32'h000A0902);
        sw_u.set_lvl(8'h01, 1'b1);
        chk("FROZEN_O", 16'h0123, FROZEN_O);
        wr(`DDI_FROZEN, 32'h00000064);
        repeat (2) @(posedge REF_CLK_I);
        chk("FROZEN_O", 16'h0064, FROZEN_O);
        sw_u.pulse(8'h02);
        chk("FROZEN_O", 16'h0065, FROZEN_O);
        sw_u.pulse(8'h06);
        chk("FROZEN_O", 16'h0064, FROZEN_O);
        sw_u.set_lvl(8'h01, 1'b0);
        sw_u.pulse(8'h02);
        chk("FROZEN_O", 16'h0064, FROZEN_O);
    endtask
    task tally_and_finish;
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge REF_CLK_I);
        RESET_N_I <= 1'b1;
        t_reset;
        t_start;
        t_lock;
        t_setup;
        t_fire;
        t_jog;
        t_hand;
        t_frz;
        tally_and_finish;
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge REF_CLK_I);
        mismatches = mismatches + 1;
        tally_and_finish;
    end
endmodule // ddi_top_tb_top
